// file: rtl/rtc_port_pkg.sv
`default_nettype none
package rtc_port_pkg;
  localparam logic [3:0] FIXED_CODE     = 4'h6;
  localparam logic       RW_READ        = 1'b1;
  localparam logic [2:0] CMD_STATUS_ONE = 3'h0;
  localparam logic [2:0] CMD_STATUS_TWO = 3'h1;
  localparam logic [2:0] CMD_CAL_FULL   = 3'h2;
  localparam logic [2:0] CMD_CAL_TIME   = 3'h3;
  localparam logic [2:0] CMD_ALARM_ONE  = 3'h4;
  localparam logic [2:0] CMD_ALARM_TWO  = 3'h5;
  localparam logic [2:0] CMD_CORRECTION = 3'h6;
  localparam logic [2:0] CMD_USER       = 3'h7;
  localparam logic [2:0] CAL_BYTES      = 3'h7;
  localparam logic [2:0] TIME_BYTES     = 3'h3;
  localparam logic [2:0] TIME_FIRST     = 3'h4;
  localparam logic [2:0] ALARM_BYTES    = 3'h3;
  localparam int         ST1_RESET_BIT  = 7;
  localparam int         ST1_HOUR24_BIT = 6;
  localparam int         ST1_SC_A_BIT   = 5;
  localparam int         ST1_SC_B_BIT   = 4;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [23:0] ALARM_RESET   = 24'h000000;
  localparam logic [7:0] MASK_YEAR      = 8'hff;
  localparam logic [7:0] MASK_MONTH     = 8'hf8;
  localparam logic [7:0] MASK_DAY       = 8'hfc;
  localparam logic [7:0] MASK_WEEKDAY   = 8'he0;
  localparam logic [7:0] MASK_HMS       = 8'hfe;
  localparam logic [7:0] MASK_AL_WEEK   = 8'he1;
  localparam logic [7:0] MASK_AL_FULL   = 8'hff;
  localparam int         WR_FIFO_DEPTH  = 16;

  typedef struct packed {
    logic [2:0] cmd;
    logic [2:0] idx;
    logic [7:0] data;
  } wr_entry_s;

  typedef struct packed {
    logic freq_output_enable;
    logic minute_irq_enable;
    logic alarm_one_enable;
    logic crystal_output_enable;
    logic scratch_c;
    logic scratch_d;
    logic alarm_two_enable;
    logic test_bit;
  } status_two_s;

  // Byte i of the calendar, year first
  function automatic logic [7:0] cal_mask(input logic [2:0] i);
    case (i)
      3'h0: cal_mask = MASK_YEAR;
      3'h1: cal_mask = MASK_MONTH;
      3'h2: cal_mask = MASK_DAY;
      3'h3: cal_mask = MASK_WEEKDAY;
      default: cal_mask = MASK_HMS;
    endcase
  endfunction : cal_mask

  function automatic logic [7:0] alarm_mask(input logic [2:0] i);
    alarm_mask = (i == 3'h0) ? MASK_AL_WEEK : MASK_AL_FULL;
  endfunction : alarm_mask
endpackage : rtc_port_pkg
`default_nettype wire

// file: rtl/rtc_serial_command_port.sv
`timescale 1ns/1ns
`default_nettype none

module wr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic [AW:0]      next_wptr;
  logic [AW:0]      next_rptr;

  assign in_ready  = (wptr - rptr) != (AW+1)'(DEPTH);
  assign out_valid = wptr != rptr;
  assign out_data  = mem[rptr[AW-1:0]];

  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    if (in_valid && in_ready) begin
      next_wptr = wptr + 1'b1;
    end
    if (out_valid && out_ready) begin
      next_rptr = rptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
    if (in_valid && in_ready) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
endmodule : wr_fifo

module rtc_serial_command_port
  import rtc_port_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Serial pins
  input  wire logic        cs_pin,
  input  wire logic        sck_pin,
  input  wire logic        sio_in,
  output logic             sio_out,
  output logic             sio_oe,
  // Timekeeper calendar
  input  wire logic [55:0] cal_now,
  input  wire logic        cal_ready,
  output logic             cal_wr,
  output logic [2:0]       cal_widx,
  output logic [7:0]       cal_wdata,
  // Timekeeper events
  input  wire logic        alarm_one_hit,
  input  wire logic        alarm_two_hit,
  input  wire logic        low_voltage_detect,
  // Configuration
  output logic             sw_reset,
  output logic             hour_24,
  output status_two_s      status_two,
  output logic [23:0]      alarm_one_or_freq_select,
  output logic [23:0]      alarm_two_time,
  output logic [7:0]       rate_correction,
  output logic [7:0]       user_storage_byte
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HEAD  = 2'b01,
    ST_WRITE = 2'b11,
    ST_READ  = 2'b10
  } port_state_e;

  // Pin synchronisers: index 0 cs, 1 sck, 2 data
  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic        sck_prev;
  logic        cs_s;
  logic        sio_s;
  logic        sck_rise;
  logic        sck_fall;

  assign cs_s     = pin_sync[0];
  assign sio_s    = pin_sync[2];
  assign sck_rise = pin_sync[1] & ~sck_prev;
  assign sck_fall = ~pin_sync[1] & sck_prev;
  assign sio_out  = 1'b0;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      sck_prev <= 1'b0;
    end else begin
      pin_meta <= {sio_in, sck_pin, cs_pin};
      pin_sync <= pin_meta;
      sck_prev <= pin_sync[1];
    end
  end

  // Serial framing group
  port_state_e state;
  port_state_e next_state;
  logic [2:0]  bitcnt;
  logic [2:0]  next_bitcnt;
  logic [7:0]  rx;
  logic [7:0]  next_rx;
  logic [7:0]  tx;
  logic [7:0]  next_tx;
  logic [2:0]  cmd;
  logic [2:0]  next_cmd;
  logic [2:0]  idx;
  logic [2:0]  next_idx;
  logic [55:0] snap;
  logic [55:0] next_snap;
  logic        next_oe;
  logic        load;
  logic        hit_code;
  logic        clear_flags;
  logic [2:0]  sel_cmd;
  logic [2:0]  sel_idx;
  logic [55:0] sel_cal;
  logic [7:0]  rd_byte;
  logic        freq_mode;
  wr_entry_s   push_entry;
  logic        push_valid;
  logic        push_ready;

  // Register group
  logic        alarm_one_flag;
  logic        alarm_two_flag;
  logic        low_voltage_flag;
  logic        power_up_flag;
  logic        scratch_a;
  logic        scratch_b;
  logic        next_alarm_one_flag;
  logic        next_alarm_two_flag;
  logic        next_low_voltage_flag;
  logic        next_power_up_flag;
  logic        next_scratch_a;
  logic        next_scratch_b;
  logic        next_hour_24;
  status_two_s next_status_two;
  logic [23:0] next_alarm_one;
  logic [23:0] next_alarm_two;
  logic [7:0]  next_correction;
  logic [7:0]  next_user;
  logic        next_sw_reset;
  logic        next_cal_wr;
  logic [2:0]  next_cal_widx;
  logic [7:0]  next_cal_wdata;
  wr_entry_s   pop_entry;
  logic        pop_valid;
  logic        pop_ready;

  function automatic logic [7:0] pick(input logic [55:0] v, input logic [2:0] i, input logic [2:0] n);
    pick = v[55 - 8*i -: 8];
    if (i >= n) begin
      pick = 8'h00;
    end
  endfunction : pick

  // Frequency layout only when minute interrupt is off
  assign freq_mode = status_two.freq_output_enable & ~status_two.minute_irq_enable;
  assign sel_cmd   = (state == ST_READ) ? cmd : next_rx[3:1];
  assign sel_idx   = (state == ST_READ) ? idx : 3'h0;
  assign sel_cal   = (state == ST_READ) ? snap : cal_now;
  assign hit_code  = next_rx[7:4] == FIXED_CODE;

  always_comb begin
    case (sel_cmd)
      CMD_STATUS_ONE: rd_byte = (sel_idx == 3'h0) ? {1'b0, hour_24, scratch_a, scratch_b,
                                alarm_one_flag, alarm_two_flag, low_voltage_flag, power_up_flag} : 8'h00;
      CMD_STATUS_TWO: rd_byte = (sel_idx == 3'h0) ? status_two : 8'h00;
      CMD_CAL_FULL:   rd_byte = pick(sel_cal, sel_idx, CAL_BYTES) & cal_mask(sel_idx);
      CMD_CAL_TIME:   rd_byte = pick(sel_cal, sel_idx + TIME_FIRST, CAL_BYTES)
                                & cal_mask(sel_idx + TIME_FIRST) & {8{sel_idx < TIME_BYTES}};
      CMD_ALARM_ONE:  rd_byte = freq_mode ? pick({alarm_one_or_freq_select, 32'h0}, sel_idx, 3'h1)
                                : pick({alarm_one_or_freq_select, 32'h0}, sel_idx, ALARM_BYTES);
      CMD_ALARM_TWO:  rd_byte = pick({alarm_two_time, 32'h0}, sel_idx, ALARM_BYTES);
      CMD_CORRECTION: rd_byte = (sel_idx == 3'h0) ? rate_correction : 8'h00;
      default:        rd_byte = (sel_idx == 3'h0) ? user_storage_byte : 8'h00;
    endcase
  end

  always_comb begin
    next_state  = state;
    next_bitcnt = bitcnt;
    next_rx     = rx;
    next_tx     = tx;
    next_cmd    = cmd;
    next_idx    = idx;
    next_snap   = snap;
    next_oe     = sio_oe;
    load        = 1'b0;
    push_valid  = 1'b0;
    push_entry  = '0;
    if (!cs_s) begin
      next_state  = ST_IDLE;
      next_bitcnt = 3'h0;
      next_oe     = 1'b0;
    end else begin
      if (state == ST_IDLE) begin
        next_state = ST_HEAD;
      end
      if (sck_rise) begin
        next_rx     = {rx[6:0], sio_s};
        next_bitcnt = bitcnt + 3'h1;
        if (bitcnt == 3'h7) begin
          case (state)
            ST_IDLE, ST_HEAD: begin
              // Any byte may carry the header until one matches
              if (hit_code) begin
                next_cmd = next_rx[3:1];
                next_idx = 3'h0;
                if (next_rx[0] == RW_READ) begin
                  next_state = ST_READ;
                  load       = 1'b1;
                  next_snap  = cal_now;
                  next_idx   = 3'h1;
                end else begin
                  next_state = ST_WRITE;
                end
              end
            end
            ST_WRITE: begin
              push_valid = 1'b1;
              push_entry = '{cmd: cmd, idx: idx, data: next_rx};
              if (idx != 3'h7) begin
                next_idx = idx + 3'h1;
              end
            end
            ST_READ: begin
              load = 1'b1;
              if (idx != 3'h7) begin
                next_idx = idx + 3'h1;
              end
            end
            default: next_state = ST_IDLE;
          endcase
        end
      end
      if (load) begin
        next_tx = rd_byte;
      end else if (sck_fall && state == ST_READ) begin
        next_oe = ~tx[7];
        next_tx = {tx[6:0], 1'b0};
      end
    end
  end

  assign clear_flags = load && sel_cmd == CMD_STATUS_ONE && sel_idx == 3'h0;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state  <= ST_IDLE;
      bitcnt <= 3'h0;
      rx     <= 8'h00;
      tx     <= 8'h00;
      cmd    <= 3'h0;
      idx    <= 3'h0;
      snap   <= '0;
      sio_oe <= 1'b0;
    end else begin
      state  <= next_state;
      bitcnt <= next_bitcnt;
      rx     <= next_rx;
      tx     <= next_tx;
      cmd    <= next_cmd;
      idx    <= next_idx;
      snap   <= next_snap;
      sio_oe <= next_oe;
    end
  end

  // Write bytes queue here, 16 deep, so a busy timekeeper loses only bytes that find the queue full
  wr_fifo #(
    .WIDTH ($bits(wr_entry_s)),
    .DEPTH (WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_entry),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_entry)
  );

  // Calendar entries wait for the timekeeper
  assign pop_ready = ~(pop_entry.cmd inside {CMD_CAL_FULL, CMD_CAL_TIME}) | cal_ready;

  always_comb begin
    next_alarm_one_flag   = alarm_one_flag;
    next_alarm_two_flag   = alarm_two_flag;
    next_low_voltage_flag = low_voltage_flag | low_voltage_detect;
    next_power_up_flag    = power_up_flag;
    next_scratch_a        = scratch_a;
    next_scratch_b        = scratch_b;
    next_hour_24          = hour_24;
    next_status_two       = status_two;
    next_alarm_one        = alarm_one_or_freq_select;
    next_alarm_two        = alarm_two_time;
    next_correction       = rate_correction;
    next_user             = user_storage_byte;
    next_sw_reset         = 1'b0;
    next_cal_wr           = 1'b0;
    next_cal_widx         = cal_widx;
    next_cal_wdata        = cal_wdata;
    if (clear_flags) begin
      next_alarm_one_flag = 1'b0;
      next_alarm_two_flag = 1'b0;
      next_power_up_flag  = 1'b0;
    end
    if (pop_valid && pop_ready && pop_entry.idx == 3'h0) begin
      case (pop_entry.cmd)
        CMD_STATUS_ONE: begin
          if (pop_entry.data[ST1_RESET_BIT]) begin
            next_sw_reset       = 1'b1;
            next_alarm_one_flag = 1'b0;
            next_alarm_two_flag = 1'b0;
            next_scratch_a      = 1'b0;
            next_scratch_b      = 1'b0;
            next_hour_24        = 1'b0;
            next_status_two     = REG_RESET;
            next_alarm_one      = ALARM_RESET;
            next_alarm_two      = ALARM_RESET;
            next_correction     = REG_RESET;
          end else begin
            next_hour_24   = pop_entry.data[ST1_HOUR24_BIT];
            next_scratch_a = pop_entry.data[ST1_SC_A_BIT];
            next_scratch_b = pop_entry.data[ST1_SC_B_BIT];
          end
        end
        CMD_STATUS_TWO: next_status_two = pop_entry.data;
        CMD_CORRECTION: next_correction = pop_entry.data;
        CMD_USER:       next_user = pop_entry.data;
        CMD_ALARM_ONE: begin
          if (freq_mode) begin
            next_alarm_one[23:16] = pop_entry.data;
          end
        end
        default: ;
      endcase
    end
    if (pop_valid && pop_ready) begin
      case (pop_entry.cmd)
        CMD_CAL_FULL, CMD_CAL_TIME: begin
          next_cal_widx = (pop_entry.cmd == CMD_CAL_TIME) ? pop_entry.idx + TIME_FIRST : pop_entry.idx;
          next_cal_wdata = pop_entry.data & cal_mask(next_cal_widx);
          next_cal_wr = (pop_entry.cmd == CMD_CAL_TIME) ? pop_entry.idx < TIME_BYTES
                                                        : pop_entry.idx < CAL_BYTES;
        end
        CMD_ALARM_ONE: begin
          if (!freq_mode && pop_entry.idx < ALARM_BYTES) begin
            next_alarm_one[23 - 8*pop_entry.idx -: 8] = pop_entry.data & alarm_mask(pop_entry.idx);
          end
        end
        CMD_ALARM_TWO: begin
          if (pop_entry.idx < ALARM_BYTES) begin
            next_alarm_two[23 - 8*pop_entry.idx -: 8] = pop_entry.data & alarm_mask(pop_entry.idx);
          end
        end
        default: ;
      endcase
    end
    // A match in the clearing cycle survives
    if (alarm_one_hit) begin
      next_alarm_one_flag = 1'b1;
    end
    if (alarm_two_hit) begin
      next_alarm_two_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      alarm_one_flag           <= 1'b0;
      alarm_two_flag           <= 1'b0;
      low_voltage_flag         <= 1'b0;
      power_up_flag            <= 1'b1;
      scratch_a                <= 1'b0;
      scratch_b                <= 1'b0;
      hour_24                  <= 1'b0;
      status_two               <= REG_RESET;
      alarm_one_or_freq_select <= ALARM_RESET;
      alarm_two_time           <= ALARM_RESET;
      rate_correction          <= REG_RESET;
      user_storage_byte        <= REG_RESET;
      sw_reset                 <= 1'b0;
      cal_wr                   <= 1'b0;
      cal_widx                 <= 3'h0;
      cal_wdata                <= 8'h00;
    end else begin
      alarm_one_flag           <= next_alarm_one_flag;
      alarm_two_flag           <= next_alarm_two_flag;
      low_voltage_flag         <= next_low_voltage_flag;
      power_up_flag            <= next_power_up_flag;
      scratch_a                <= next_scratch_a;
      scratch_b                <= next_scratch_b;
      hour_24                  <= next_hour_24;
      status_two               <= next_status_two;
      alarm_one_or_freq_select <= next_alarm_one;
      alarm_two_time           <= next_alarm_two;
      rate_correction          <= next_correction;
      user_storage_byte        <= next_user;
      sw_reset                 <= next_sw_reset;
      cal_wr                   <= next_cal_wr;
      cal_widx                 <= next_cal_widx;
      cal_wdata                <= next_cal_wdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_last_bit;
    cs_s && sck_rise && bitcnt == 3'h7 && state inside {ST_IDLE, ST_HEAD};
  endsequence

  sequence s_reset_pulse;
    sw_reset ##1 !sw_reset;
  endsequence

  a_bad_header: assert property (s_last_bit and (next_rx[7:4] != FIXED_CODE) |=> state == ST_HEAD)
    else $error("bad header left header phase");
  a_header_taken: assert property (s_last_bit and hit_code |=> state inside {ST_READ, ST_WRITE})
    else $error("valid header not taken");
  a_msb_out: assert property (state == ST_READ && cs_s && sck_fall && !load |=> sio_oe == !$past(tx[7]))
    else $error("wrong bit driven");
  a_reset_bit_read: assert property (clear_flags |=> tx[7] == 1'b0)
    else $error("reset bit read as one");
  a_alarm_clear: assert property (clear_flags && !alarm_one_hit |=> !alarm_one_flag)
    else $error("alarm flag not cleared by read");
  a_alarm_set: assert property (alarm_two_hit |=> alarm_two_flag)
    else $error("alarm flag not set");
  a_power_clear: assert property (clear_flags |=> !power_up_flag)
    else $error("power-up flag not cleared");
  a_lowv_sticky: assert property (low_voltage_flag |=> low_voltage_flag [*2])
    else $error("low-voltage flag dropped");
  a_cs_release: assert property (!cs_s |=> !sio_oe && state == ST_IDLE)
    else $error("data line held after deselect");
  a_snap_take: assert property (s_last_bit and hit_code && next_rx[0] |=> snap == $past(cal_now))
    else $error("calendar snapshot missed");
  a_soft_reset: assert property (pop_valid && pop_ready && pop_entry.cmd == CMD_STATUS_ONE && pop_entry.idx == 3'h0
                                 && pop_entry.data[ST1_RESET_BIT] |=> s_reset_pulse)
    else $error("software reset pulse missing");
  a_cal_unused: assert property (cal_wr |-> (cal_wdata & ~cal_mask(cal_widx)) == 8'h00)
    else $error("unused calendar bit written");
endmodule : rtc_serial_command_port
`default_nettype wire

// file: testbench/serial_host.sv
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  // Clock
  input  wire logic clk,
  // Link
  input  wire logic line,
  output logic      cs,
  output logic      sck,
  output logic      drv_en,
  output logic      drv_bit
);
  initial begin
    cs = 1'b0;
    sck = 1'b0;
    drv_en = 1'b0;
    drv_bit = 1'b1;
  end

  task automatic sel();
    @(posedge clk);
    cs <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : sel

  // Letting go of the line too, so no stale host bit is read back
  task automatic desel();
    repeat (4) @(posedge clk);
    cs <= 1'b0;
    drv_en <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : desel

  // Bits change while sck is low and are read just before the rise
  task automatic xfer(input logic [7:0] tx, input logic drive, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      drv_en <= drive;
      drv_bit <= tx[i];
      repeat (4) @(posedge clk);
      rx[i] = line;
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
  endtask : xfer
endmodule : serial_host
`default_nettype wire

// file: testbench/rtc_serial_command_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_serial_command_port_tb_top;
  import rtc_port_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, cal_ready = 1'b1, a1 = 1'b0, a2 = 1'b0, lv = 1'b0, sw_seen = 1'b0;
  logic        cs, sck, den, dbit, sio_oe, sio_out, cal_wr, sw_reset, hour_24, line;
  logic [55:0] cal_now = 56'h53_48_94_40_52_4c_98;
  logic [2:0]  cal_widx;
  logic [7:0]  cal_wdata, rate_corr, user_byte, rx;
  logic [23:0] al1, al2;
  status_two_s st2;
  logic [7:0]  wb [7];
  logic [7:0]  rb [7];
  logic [7:0]  msk [7] = '{8'hff, 8'hf8, 8'hfc, 8'he0, 8'hfe, 8'hfe, 8'hfe};
  logic [10:0] wq [$];
  int          error_cnt = 0, total_checks = 0, cycles = 0;

  // Pull-up unless a party drives
  assign line = sio_oe ? sio_out : (den ? dbit : 1'b1);

  rtc_serial_command_port u_dut (.clk(clk), .rstn(rstn), .cs_pin(cs), .sck_pin(sck), .sio_in(line),
    .sio_out(sio_out), .sio_oe(sio_oe), .cal_now(cal_now), .cal_ready(cal_ready), .cal_wr(cal_wr),
    .cal_widx(cal_widx), .cal_wdata(cal_wdata), .alarm_one_hit(a1), .alarm_two_hit(a2),
    .low_voltage_detect(lv), .sw_reset(sw_reset), .hour_24(hour_24), .status_two(st2),
    .alarm_one_or_freq_select(al1), .alarm_two_time(al2), .rate_correction(rate_corr),
    .user_storage_byte(user_byte));
  serial_host u_host (.clk(clk), .line(line), .cs(cs), .sck(sck), .drv_en(den), .drv_bit(dbit));

  initial begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cal_wr === 1'b1) wq.push_back({cal_widx, cal_wdata});
    if (sw_reset === 1'b1) sw_seen = 1'b1;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors=%0d checks=%0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic fill(input logic [7:0] v);
    foreach (wb[i]) wb[i] = v;
  endtask : fill

  task automatic txn(input logic [2:0] c, input logic rd, input int n);
    u_host.sel();
    u_host.xfer({FIXED_CODE, c, rd}, 1'b1, 8, rx);
    for (int i = 0; i < n; i++) u_host.xfer(wb[i], !rd, 8, rb[i]);
    u_host.desel();
  endtask : txn

  task automatic t_flags();
    txn(CMD_STATUS_ONE, 1'b1, 1);
    chk(rb[0], 8'h01);
    a1 <= 1'b1;
    a2 <= 1'b1;
    lv <= 1'b1;
    @(posedge clk);
    a1 <= 1'b0;
    a2 <= 1'b0;
    lv <= 1'b0;
    txn(CMD_STATUS_ONE, 1'b1, 1);
    chk(rb[0], 8'h0e);
    txn(CMD_STATUS_ONE, 1'b1, 1);
    chk(rb[0], 8'h02);
  endtask : t_flags

  task automatic t_status();
    fill(8'h70);
    txn(CMD_STATUS_ONE, 1'b0, 1);
    chk(hour_24, 1'b1);
    txn(CMD_STATUS_ONE, 1'b1, 1);
    chk(rb[0], 8'h72);
    fill(8'h3c);
    txn(CMD_STATUS_TWO, 1'b0, 1);
    chk(st2, 8'h3c);
    txn(CMD_STATUS_TWO, 1'b1, 1);
    chk(rb[0], 8'h3c);
    fill(8'h80);
    txn(CMD_STATUS_ONE, 1'b0, 1);
    chk({sw_seen, hour_24}, 2'b10);
    txn(CMD_STATUS_ONE, 1'b1, 1);
    chk(rb[0], 8'h02);
  endtask : t_status

  task automatic t_regs();
    fill(8'hff);
    txn(CMD_ALARM_ONE, 1'b0, 3);
    chk(al1, 24'he1ffff);
    txn(CMD_ALARM_TWO, 1'b0, 3);
    chk(al2, 24'he1ffff);
    txn(CMD_ALARM_TWO, 1'b1, 3);
    chk({rb[0], rb[1], rb[2]}, 24'he1ffff);
    fill(8'h80);
    txn(CMD_STATUS_TWO, 1'b0, 1);
    fill(8'hab);
    txn(CMD_ALARM_ONE, 1'b0, 1);
    chk(al1[23:16], 8'hab);
    txn(CMD_ALARM_ONE, 1'b1, 2);
    chk({rb[0], rb[1]}, 16'hab00);
    fill(8'h5a);
    txn(CMD_CORRECTION, 1'b0, 1);
    chk(rate_corr, 8'h5a);
    txn(CMD_CORRECTION, 1'b1, 1);
    chk(rb[0], 8'h5a);
  endtask : t_regs

  task automatic t_user();
    fill(8'h3c);
    txn(CMD_USER, 1'b0, 1);
    chk(user_byte, 8'h3c);
    u_host.sel();
    u_host.xfer(8'h7e, 1'b1, 8, rx);
    u_host.xfer({FIXED_CODE, CMD_USER, 1'b0}, 1'b1, 8, rx);
    u_host.xfer(8'hc3, 1'b1, 8, rx);
    u_host.desel();
    chk(user_byte, 8'hc3);
    u_host.sel();
    u_host.xfer(8'h5e, 1'b1, 8, rx);
    u_host.xfer(8'h00, 1'b1, 8, rx);
    u_host.desel();
    chk(user_byte, 8'hc3);
    // Abort mid-byte while the device holds the line low for B3
    u_host.sel();
    u_host.xfer({FIXED_CODE, CMD_USER, 1'b1}, 1'b1, 8, rx);
    u_host.xfer(8'hff, 1'b0, 4, rx);
    chk(rx[7:4], 4'hc);
    u_host.desel();
    chk(sio_oe, 1'b0);
  endtask : t_user

  task automatic t_cal();
    u_host.sel();
    u_host.xfer({FIXED_CODE, CMD_CAL_FULL, 1'b1}, 1'b1, 8, rx);
    repeat (2) @(posedge clk);
    cal_now <= '0;
    for (int i = 0; i < 7; i++) u_host.xfer(8'hff, 1'b0, 8, rb[i]);
    u_host.desel();
    chk({rb[0], rb[1], rb[2], rb[3], rb[4], rb[5], rb[6]}, 56'h53_48_94_40_52_4c_98);
    // Stalled timekeeper: 17 bytes offered, the last finds the buffer full
    cal_ready <= 1'b0;
    fill(8'hff);
    txn(CMD_CAL_FULL, 1'b0, 7);
    txn(CMD_CAL_FULL, 1'b0, 7);
    txn(CMD_CAL_TIME, 1'b0, 3);
    chk(wq.size(), 0);
    cal_ready <= 1'b1;
    for (int i = 0; i < 100 && wq.size() < 16; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(wq.size(), 16);
    for (int i = 0; i < 16 && i < wq.size(); i++) begin
      rx = (i < 14) ? 8'(i % 7) : 8'(i - 10);
      chk(wq[i], {rx[2:0], msk[rx[2:0]]});
    end
    // Short time read: hour, minute, second only, unused B0 reads zero
    cal_now <= 56'h00_00_00_00_a5_7f_3b;
    txn(CMD_CAL_TIME, 1'b1, 3);
    chk({rb[0], rb[1], rb[2]}, 24'ha47e3a);
  endtask : t_cal

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_flags();
    t_status();
    t_regs();
    t_user();
    t_cal();
    close_out();
  end
endmodule : rtc_serial_command_port_tb_top
`default_nettype wire
